// ---- core/mni_map.svh ----
// constants for the copy, store and no-op instruction executor
// assumes a 14-bit instruction word with four clock phases per instruction cycle
`ifndef MNI_MAP_SVH
`define MNI_MAP_SVH

`define MNI_INSTR_W 14
`define MNI_ADDR_W 7
`define MNI_DATA_W 8
`define MNI_PHASES 4

// field positions inside the instruction word
`define MNI_TOP_HI 13
`define MNI_TOP_LO 12
`define MNI_OPC_HI 11
`define MNI_OPC_LO 8
`define MNI_DEST_BIT 7
`define MNI_ADDR_HI 6
`define MNI_ADDR_LO 0
`define MNI_NOP_DC_HI 6
`define MNI_NOP_DC_LO 5
`define MNI_NOP_LOW_HI 4

// field values
`define MNI_TOP_VAL 2'h0
`define MNI_OPC_COPY 4'h8
`define MNI_OPC_ZERO 4'h0
`define MNI_NOP_LOW_VAL 5'h00
`define MNI_DATA_ZERO 8'h00

// reset values of the output registers
`define MNI_ADDR_RST 7'h00
`define MNI_DATA_RST 8'h00

`endif

// ---- core/mni_pkg.sv ----
// types shared by the instruction executor and its phase generator
// assumes the constants header sits on the include path
`include "mni_map.svh"

package mni_pkg;

  typedef enum logic [1:0] {
    MNI_Q1 = 2'b00,
    MNI_Q2 = 2'b01,
    MNI_Q3 = 2'b10,
    MNI_Q4 = 2'b11
  } mni_phase_t;

  typedef enum logic [2:0] {
    MNI_OP_NONE = 3'b000,
    MNI_OP_COPY = 3'b001,
    MNI_OP_STORE = 3'b010,
    MNI_OP_NOP = 3'b011,
    MNI_OP_OTHER = 3'b100
  } mni_op_t;

  // request toward the file register array
  typedef struct packed {
    logic rdEn;
    logic wrEn;
    logic [`MNI_ADDR_W-1:0] addr;
    logic [`MNI_DATA_W-1:0] wrData;
  } mni_file_req_t;

  // write request toward the working register
  typedef struct packed {
    logic wrEn;
    logic [`MNI_DATA_W-1:0] data;
  } mni_work_req_t;

  // zero flag update
  typedef struct packed {
    logic wrEn;
    logic val;
  } mni_zero_req_t;

endpackage

// ---- core/mni_phase_gen.sv ----
// four-phase divider: one instruction cycle is four clk_sys cycles
// assumes the core starts fetching at the first phase after reset release
`timescale 1ns/1ps
`default_nettype none
`include "mni_map.svh"

module mni_phase_gen #(
  parameter int PHASES = `MNI_PHASES
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  output mni_pkg::mni_phase_t phase,
  output logic cycleStart
);
  import mni_pkg::*;

  typedef struct packed {
    mni_phase_t phase;
  } mni_pg_state_t;

  mni_pg_state_t st_q, st_d;

  // the phase encoding only covers exactly four phases
  if (PHASES != 4) begin : g_bad_phases
    $error("mni_phase_gen: PHASES must be 4");
  end

  // advance one phase per clock, wrapping after the fourth
  always_comb begin
    st_d = st_q;
    st_d.phase = mni_phase_t'(st_q.phase + 2'h1);
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{phase: MNI_Q1};
    end else begin
      st_q <= st_d;
    end
  end

  assign phase = st_q.phase;
  assign cycleStart = (st_q.phase == MNI_Q1); // handshake level during the decode phase

endmodule
`default_nettype wire

// ---- core/mni_exec.sv ----
// executor for the copy-file, store-working and no-op instructions
// assumes the file array returns read data one clock after a read strobe,
// and that the instruction word is held stable during the decode phase
`timescale 1ns/1ps
`default_nettype none
`include "mni_map.svh"

module mni_exec #(
  parameter int INSTR_W = `MNI_INSTR_W,
  parameter int ADDR_W = `MNI_ADDR_W,
  parameter int DATA_W = `MNI_DATA_W
) (
  input wire logic clk_sys,
  input wire logic reset_n,
  input wire logic instrValid,
  input wire logic [`MNI_INSTR_W-1:0] instrWord,
  input wire logic [`MNI_DATA_W-1:0] fileRdData,
  input wire logic [`MNI_DATA_W-1:0] workValue,
  output mni_pkg::mni_phase_t phase,
  output logic decodeReady,
  output logic foreignInstr,
  output mni_pkg::mni_file_req_t fileReq,
  output mni_pkg::mni_work_req_t workReq,
  output mni_pkg::mni_zero_req_t zeroReq
);
  import mni_pkg::*;

  // the struct carriers are sized by the header, so the widths are fixed
  if (INSTR_W != `MNI_INSTR_W || ADDR_W != `MNI_ADDR_W || DATA_W != `MNI_DATA_W) begin : g_bad
    $error("mni_exec: widths must match the instruction format");
  end

  typedef struct packed {
    mni_op_t op;
    logic dest;
    logic foreign;
    mni_file_req_t file;
    mni_work_req_t work;
    mni_zero_req_t zero;
  } mni_state_t;

  mni_state_t st_q, st_d;
  logic decodeNow;

  // classify one instruction word; shared by the datapath and the checks
  function automatic mni_op_t decodeOp(input logic [`MNI_INSTR_W-1:0] w);
    mni_op_t r;
    r = MNI_OP_OTHER;
    if (w[`MNI_TOP_HI:`MNI_TOP_LO] == `MNI_TOP_VAL) begin
      if (w[`MNI_OPC_HI:`MNI_OPC_LO] == `MNI_OPC_COPY) begin
        r = MNI_OP_COPY;
      end else if (w[`MNI_OPC_HI:`MNI_OPC_LO] == `MNI_OPC_ZERO) begin
        if (w[`MNI_DEST_BIT]) begin
          r = MNI_OP_STORE;
        end else if (w[`MNI_NOP_LOW_HI:0] == `MNI_NOP_LOW_VAL) begin
          r = MNI_OP_NOP;
        end
      end
    end
    return r;
  endfunction

  mni_phase_gen #(
    .PHASES(`MNI_PHASES)
  ) u_phase (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .phase(phase),
    .cycleStart(decodeReady)
  );

  assign decodeNow = decodeReady && instrValid;

  // one phase step per clock; strobes are set a clock ahead so they leave flip-flops
  always_comb begin
    st_d = st_q;
    unique case (phase)
      MNI_Q1: begin
        // decode; an absent word behaves as a bubble
        st_d.op = decodeNow ? decodeOp(instrWord) : MNI_OP_NONE;
        st_d.dest = instrWord[`MNI_DEST_BIT];
        st_d.foreign = decodeNow && (decodeOp(instrWord) == MNI_OP_OTHER);
        // address is captured even for a bubble; without a strobe nobody uses it
        st_d.file.addr = instrWord[`MNI_ADDR_HI:`MNI_ADDR_LO];
        st_d.file.rdEn = decodeNow && (decodeOp(instrWord) == MNI_OP_COPY);
      end
      MNI_Q2: begin
        st_d.foreign = 1'b0;
        st_d.file.rdEn = 1'b0;
      end
      MNI_Q3: begin
        // read data is valid now; stage the write to the destination
        if (st_q.op == MNI_OP_COPY) begin
          st_d.work.wrEn = !st_q.dest;
          st_d.work.data = fileRdData;
          st_d.file.wrEn = st_q.dest;
          st_d.file.wrData = fileRdData;
          st_d.zero.wrEn = 1'b1;
          st_d.zero.val = (fileRdData == `MNI_DATA_ZERO);
        end else if (st_q.op == MNI_OP_STORE) begin
          // flags are left alone on purpose
          st_d.file.wrEn = 1'b1;
          st_d.file.wrData = workValue;
        end
        // a no-op stages nothing, so no register or flag can move
      end
      MNI_Q4: begin
        // writes land on this edge; everything drops before the next decode
        st_d.op = MNI_OP_NONE;
        st_d.file.wrEn = 1'b0;
        st_d.work.wrEn = 1'b0;
        st_d.zero.wrEn = 1'b0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      st_q <= '{op: MNI_OP_NONE, dest: 1'b0, foreign: 1'b0,
                file: '{rdEn: 1'b0, wrEn: 1'b0, addr: `MNI_ADDR_RST, wrData: `MNI_DATA_RST},
                work: '{wrEn: 1'b0, data: `MNI_DATA_RST},
                zero: '{wrEn: 1'b0, val: 1'b0}};
    end else begin
      st_q <= st_d;
    end
  end

  assign fileReq = st_q.file;
  assign workReq = st_q.work;
  assign zeroReq = st_q.zero;
  assign foreignInstr = st_q.foreign;

  // checks; all share the one clock and the reset
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  logic anyStrobe;
  assign anyStrobe = fileReq.rdEn || fileReq.wrEn || workReq.wrEn || zeroReq.wrEn;

  sequence s_copy_w;
    decodeNow && decodeOp(instrWord) == MNI_OP_COPY && !instrWord[`MNI_DEST_BIT];
  endsequence

  sequence s_copy_f;
    decodeNow && decodeOp(instrWord) == MNI_OP_COPY && instrWord[`MNI_DEST_BIT];
  endsequence

  sequence s_read_then_drop;
    fileReq.rdEn && !fileReq.wrEn ##1 !fileReq.rdEn;
  endsequence

  a_copy_read_phase: assert property ((s_copy_w or s_copy_f) |=> s_read_then_drop)
    else $error("copy did not read the file in the second phase");

  a_copy_one_cycle: assert property ((s_copy_w or s_copy_f) |-> ##4 !anyStrobe)
    else $error("copy still active after one instruction cycle");

  a_copy_to_work: assert property (s_copy_w |-> ##3 (workReq.wrEn && !fileReq.wrEn
      && workReq.data == $past(fileRdData)))
    else $error("copy to working register wrong");

  a_copy_to_file: assert property (s_copy_f |-> ##3 (fileReq.wrEn && !workReq.wrEn
      && fileReq.wrData == $past(fileRdData)
      && fileReq.addr == $past(instrWord[`MNI_ADDR_HI:0], 3)))
    else $error("copy back to file register wrong");

  a_zero_flag_update: assert property ((s_copy_w or s_copy_f) |-> ##3 (zeroReq.wrEn
      && zeroReq.val == ($past(fileRdData) == `MNI_DATA_ZERO)))
    else $error("zero flag not taken from moved value");

  a_store_working: assert property ((decodeNow && decodeOp(instrWord) == MNI_OP_STORE)
      |-> ##3 (fileReq.wrEn && fileReq.wrData == $past(workValue) && !zeroReq.wrEn
      && !workReq.wrEn && !fileReq.rdEn))
    else $error("store of working register wrong or touched flags");

  a_nop_quiet: assert property ((decodeNow && decodeOp(instrWord) == MNI_OP_NOP)
      |=> (!anyStrobe && !foreignInstr) [*4])
    else $error("no-op produced activity");

  a_zero_only_copy: assert property (zeroReq.wrEn |-> $past(st_q.op) == MNI_OP_COPY)
    else $error("zero flag written outside a copy");

  // a word that is none of the three only raises its flag, for one clock, and moves nothing
  sequence s_foreign_word;
    decodeNow && decodeOp(instrWord) == MNI_OP_OTHER;
  endsequence

  sequence s_store_word;
    decodeNow && decodeOp(instrWord) == MNI_OP_STORE;
  endsequence

  a_foreign_pulse: assert property (s_foreign_word |=> foreignInstr ##1 !foreignInstr)
    else $error("foreign flag is not a single pulse");

  a_foreign_quiet: assert property (s_foreign_word |=> (!anyStrobe) [*4])
    else $error("foreign word moved data");

  // an empty decode slot must act like a no-op, since the core fills stalls with it
  a_bubble_quiet: assert property ((decodeReady && !instrValid) |=>
      (!anyStrobe && !foreignInstr) [*4])
    else $error("empty decode slot produced activity");

  // the read goes to the register named by the decoded word
  a_copy_read_addr: assert property ((s_copy_w or s_copy_f) |=>
      fileReq.addr == $past(instrWord[`MNI_ADDR_HI:`MNI_ADDR_LO]))
    else $error("copy read from the wrong file address");

  a_store_addr: assert property (s_store_word |-> ##3
      fileReq.addr == $past(instrWord[`MNI_ADDR_HI:`MNI_ADDR_LO], 3))
    else $error("store wrote the wrong file address");

  // a store must not read the array, nor touch the working register or any flag
  a_store_no_side: assert property (s_store_word |=>
      (!fileReq.rdEn && !workReq.wrEn && !zeroReq.wrEn) [*4])
    else $error("store touched more than its file register");

  // the working strobe has one legal source and the file strobe two; a stray one would corrupt core state
  a_work_wr_source: assert property (workReq.wrEn |->
      $past(st_q.op) == MNI_OP_COPY && !$past(st_q.dest))
    else $error("working register written outside a copy to it");

  a_file_wr_source: assert property (fileReq.wrEn |->
      $past(st_q.op) == MNI_OP_STORE || ($past(st_q.op) == MNI_OP_COPY && $past(st_q.dest)))
    else $error("file register written outside a store or copy back");

  // strobes last one clock so each instruction lands exactly once
  a_strobe_single: assert property ((fileReq.wrEn || workReq.wrEn || zeroReq.wrEn) |=>
      !(fileReq.wrEn || workReq.wrEn || zeroReq.wrEn))
    else $error("write strobe held for more than one clock");

  a_phase_wrap: assert property (phase == MNI_Q4 |=> phase == MNI_Q1 && decodeReady)
    else $error("instruction cycle is not four clocks");

endmodule
`default_nettype wire

// ---- tb/mni_file_model.sv ----
// file register array, working register and zero flag facing the executor
// assumes one-clock read latency and writes landing on the strobe edge
`timescale 1ns/1ps
`default_nettype none

module mni_file_model
  import mni_pkg::*;
(
  input wire logic clk_sys,
  input wire mni_pkg::mni_file_req_t fileReq,
  input wire mni_pkg::mni_work_req_t workReq,
  input wire mni_pkg::mni_zero_req_t zeroReq,
  output logic [7:0] fileRdData,
  output logic [7:0] workValue,
  output logic zeroFlag
);
  logic [7:0] mem [128];

  // read data is good for one clock only; it flips afterwards so a late sample shows
  always @(posedge clk_sys) begin
    fileRdData <= fileReq.rdEn ? mem[fileReq.addr] : ~fileRdData;
    if (fileReq.wrEn) begin
      mem[fileReq.addr] <= fileReq.wrData;
    end
    if (workReq.wrEn) begin
      workValue <= workReq.data;
    end
    if (zeroReq.wrEn) begin
      zeroFlag <= zeroReq.val;
    end
  end
endmodule

`default_nettype wire

// ---- tb/mni_exec_tb.sv ----
// self-checking bench for the copy, store and no-op executor
// assumes the package, executor and file model are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "mni_map.svh"

module mni_exec_tb;
  import mni_pkg::*;
  logic clk_sys, reset_n, instrValid, zeroFlag, decodeReady, foreignInstr;
  logic [13:0] instrWord;
  logic [7:0] fileRdData, workValue;
  mni_phase_t phase;
  mni_file_req_t fileReq;
  mni_work_req_t workReq;
  mni_zero_req_t zeroReq;
  int error_cnt = 0;
  int n_tests = 0;
  int nForeign = 0;
  int nStrobe = 0;
  int nFileWr = 0;

  mni_exec u_mni_exec (.clk_sys(clk_sys), .reset_n(reset_n), .instrValid(instrValid),
    .instrWord(instrWord), .fileRdData(fileRdData), .workValue(workValue), .phase(phase),
    .decodeReady(decodeReady), .foreignInstr(foreignInstr), .fileReq(fileReq),
    .workReq(workReq), .zeroReq(zeroReq));
  mni_file_model u_mni_file_model (.clk_sys(clk_sys), .fileReq(fileReq), .workReq(workReq),
    .zeroReq(zeroReq), .fileRdData(fileRdData), .workValue(workValue), .zeroFlag(zeroFlag));

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  // tally pulses mid-cycle, where the registered outputs have settled
  always @(negedge clk_sys) begin
    if (foreignInstr !== 1'b0) nForeign++;
    if ((fileReq.wrEn | workReq.wrEn | zeroReq.wrEn) !== 1'b0) nStrobe++;
    if (fileReq.wrEn !== 1'b0) nFileWr++;
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      error_cnt++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // put one word in a Q1 slot, then wait until its Q4 writes have landed
  task automatic run(input logic [13:0] w);
    @(negedge clk_sys);
    while (phase !== MNI_Q4) @(negedge clk_sys);
    @(posedge clk_sys);
    instrValid <= 1'b1;
    instrWord <= w;
    @(negedge clk_sys);
    chk({7'h00, decodeReady}, 8'h01);
    @(posedge clk_sys);
    instrValid <= 1'b0;
    instrWord <= ~w;  // junk outside Q1 must be ignored
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask

  task automatic t_copy_work;
    int w0 = nFileWr;
    u_mni_file_model.mem[7'h15] = 8'h00;
    u_mni_file_model.workValue = 8'h77;
    u_mni_file_model.zeroFlag = 1'b0;
    run(14'h0815);
    chk(8'(nFileWr - w0), 8'h00);
    chk(u_mni_file_model.workValue, 8'h00);
    chk(u_mni_file_model.mem[7'h15], 8'h00);
    chk({7'h00, u_mni_file_model.zeroFlag}, 8'h01);
  endtask

  task automatic t_copy_self;
    int s0 = nStrobe;
    int w0 = nFileWr;
    u_mni_file_model.mem[7'h7f] = 8'ha5;
    u_mni_file_model.zeroFlag = 1'b1;
    run(14'h08ff);
    chk(8'(nFileWr - w0), 8'h01);
    chk(u_mni_file_model.mem[7'h7f], 8'ha5);
    chk(u_mni_file_model.workValue, 8'h00);
    chk({7'h00, u_mni_file_model.zeroFlag}, 8'h00);
    chk(8'(nStrobe - s0), 8'h01);
  endtask

  task automatic t_store;
    int w0 = nFileWr;
    u_mni_file_model.workValue = 8'h3c;
    u_mni_file_model.zeroFlag = 1'b1;
    run(14'h00ff);
    chk(8'(nFileWr - w0), 8'h01);
    chk(u_mni_file_model.workValue, 8'h3c);
    chk(u_mni_file_model.mem[7'h7f], 8'h3c);
    chk({7'h00, u_mni_file_model.zeroFlag}, 8'h01);
  endtask

  // every don't-care combination must stay silent
  task automatic t_nop;
    int s0 = nStrobe;
    int f0 = nForeign;
    for (int d = 0; d < 4; d++) begin
      run(14'(d << 5));
    end
    chk(8'(nStrobe - s0), 8'h00);
    chk(8'(nForeign - f0), 8'h00);
    chk(u_mni_file_model.workValue, 8'h3c);
  endtask

  task automatic t_foreign;
    int s0 = nStrobe;
    int f0 = nForeign;
    run(14'h0100);
    chk(8'(nForeign - f0), 8'h01);
    chk(8'(nStrobe - s0), 8'h00);
  endtask

  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  initial begin
    reset_n = 1'b0;
    instrValid = 1'b0;
    instrWord = 14'h0000;
    repeat (3) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_copy_work();
    t_copy_self();
    t_store();
    t_nop();
    t_foreign();
    report_and_stop();
  end

  // watchdog: the sequence needs under 100 clocks, so 1000 means a hang
  initial begin
    #20000;
    error_cnt++;
    report_and_stop();
  end
endmodule

`default_nettype wire
